// ==== logic/lac_sequencer.sv ====
// Lead-acid charge sequencer with Avalon-MM register slave
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module lac_sequencer import lac_pkg::*; #(
  parameter int STEP_N = STEP_CYC,
  parameter int SEC_N  = SEC_CYC
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Condition inputs from the power stage
  input  wire logic        vin_near_bat,
  input  wire logic        system_fault,
  input  wire logic        bat_stable,
  input  wire logic        bat_in_range,
  input  wire logic        thermistor_open,
  input  wire logic        bat_below_2v4,
  input  wire logic        bat_above_2v6,
  input  wire logic        at_charge_voltage,
  input  wire logic        input_current_limiting,
  input  wire logic        undervoltage_limiting,
  input  wire logic        below_taper,
  input  wire logic        equalize_request_pin,
  // Commands to the power stage
  output logic      [4:0]  charge_level,
  output logic      [5:0]  charge_voltage_code,
  output logic             charger_on,
  output logic             detect_load_on,
  output logic             peak_current_mode,
  output logic             alert
);
  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic        rst_m_q, rst_s_q;
  logic [11:0] in_m_q, in_s_q;

  // Reset asserts at once, releases after two edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // Pins are asynchronous to clk
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      in_m_q <= 12'h0;
      in_s_q <= 12'h0;
    end else if (ce) begin
      in_m_q <= {vin_near_bat, system_fault, bat_stable, bat_in_range,
                 thermistor_open, bat_below_2v4, bat_above_2v6,
                 at_charge_voltage, input_current_limiting,
                 undervoltage_limiting, below_taper, equalize_request_pin};
      in_s_q <= in_m_q;
    end
  end

  logic s_vin, s_flt, s_stab, s_rng, s_ntc, s_lo, s_hi;
  logic s_cv, s_icl, s_uvcl, s_taper, s_eq;
  assign {s_vin, s_flt, s_stab, s_rng, s_ntc, s_lo, s_hi,
          s_cv, s_icl, s_uvcl, s_taper, s_eq} = in_s_q;

  // ----------------------------------------------------------------
  // Ticks
  // ----------------------------------------------------------------
  logic step_tick, sec_tick;

  lac_tick #(
    .STEP_N (STEP_N),
    .SEC_N  (SEC_N)
  ) u_tick (
    .clk       (clk),
    .rst_n     (rst_s_q),
    .ce        (ce),
    .step_tick (step_tick),
    .sec_tick  (sec_tick)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Saturating code add keeps the result inside 2V..2.6V/cell
  function automatic logic [5:0] sat_add(input logic [5:0] a, input logic [5:0] b);
    logic [6:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[6] ? V_MAX : s[5:0];
  endfunction : sat_add

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                        input logic [3:0] be);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) merge[i*8 +: 8] = w[i*8 +: 8];
    end
  endfunction : merge

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [2:0]  ctrl_q;
  logic [4:0]  target_q;
  logic [5:0]  vfloat_q, absadd_q, eqadd_q;
  logic [15:0] absmax_q, eqtime_q;
  logic        evt_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        acc, wr_acc;
  logic [31:0] st_word;
  lac_state_e  state_q;

  // Read data latched on the taking edge so it stands while waitrequest is low
  assign acc    = read & wait_q;
  assign wr_acc = write & ~wait_q;

  // Wait is held high except for the single answer cycle
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      wait_q <= 1'b1;
    end else if (ce) begin
      wait_q <= ~((read | write) & wait_q);
    end
  end

  // Writable registers; parameters gated by programmable mode
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      ctrl_q   <= R_CTRL;
      target_q <= R_TARGET;
      vfloat_q <= R_VFLOAT;
      absadd_q <= R_ABSADD;
      eqadd_q  <= R_EQADD;
      absmax_q <= R_ABSMAX;
      eqtime_q <= R_EQTIME;
    end else if (ce && wr_acc) begin
      if (address == A_CTRL)
        ctrl_q <= 3'(merge({29'h0, ctrl_q}, writedata, byteenable));
      if (ctrl_q[C_PROG]) begin
        case (address)
          A_TARGET: target_q <= 5'(merge({27'h0, target_q}, writedata, byteenable));
          A_VFLOAT: vfloat_q <= 6'(merge({26'h0, vfloat_q}, writedata, byteenable));
          A_ABSADD: absadd_q <= 6'(merge({26'h0, absadd_q}, writedata, byteenable));
          A_EQADD:  eqadd_q  <= 6'(merge({26'h0, eqadd_q}, writedata, byteenable));
          A_ABSMAX: absmax_q <= 16'(merge({16'h0, absmax_q}, writedata, byteenable));
          A_EQTIME: eqtime_q <= 16'(merge({16'h0, eqtime_q}, writedata, byteenable));
          default: ;
        endcase
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      rdata_q <= 32'h0;
    end else if (ce && acc) begin
      case (address)
        A_CTRL:   rdata_q <= {29'h0, ctrl_q};
        A_TARGET: rdata_q <= {27'h0, target_q};
        A_VFLOAT: rdata_q <= {26'h0, vfloat_q};
        A_ABSADD: rdata_q <= {26'h0, absadd_q};
        A_EQADD:  rdata_q <= {26'h0, eqadd_q};
        A_ABSMAX: rdata_q <= {16'h0, absmax_q};
        A_EQTIME: rdata_q <= {16'h0, eqtime_q};
        A_STATUS: rdata_q <= st_word;
        A_EVENT:  rdata_q <= {31'h0, evt_q};
        default:  rdata_q <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  logic       suspend_req;
  logic       det_fault;
  logic [2:0] sec_cnt_q;
  logic [15:0] abs_tmr_q, eq_tmr_q;
  logic       cv_seen_q, eq_arm_q, eq_prev_q, low_q;
  logic       regulate;

  assign suspend_req = s_vin | s_flt | ctrl_q[C_SUSPEND];
  assign regulate = s_cv | s_icl | s_uvcl;
  // Fault when open/short test fails or thermistor reads open during detect or open/short
  assign det_fault = ((state_q == ST_OPENSHORT) && sec_tick &&
                      (sec_cnt_q + 3'h1 >= OS_SECS) && !s_rng) ||
                     ((state_q == ST_DETECT || state_q == ST_OPENSHORT) && s_ntc);

  // Phase transitions; suspend wins from every state
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      state_q <= ST_SUSPEND;
    end else if (ce) begin
      if (suspend_req) begin
        state_q <= ST_SUSPEND;
      end else begin
        case (state_q)
          ST_SUSPEND: state_q <= ST_DETECT;
          ST_DETECT: begin
            if (s_ntc) state_q <= ST_FAULT;
            else if (sec_tick && sec_cnt_q + 3'h1 >= DET_SECS)
              state_q <= s_stab ? ST_SOFTSTART : ST_OPENSHORT;
          end
          ST_OPENSHORT: begin
            if (det_fault) state_q <= ST_FAULT;
            else if (sec_tick && sec_cnt_q + 3'h1 >= OS_SECS)
              state_q <= ST_SOFTSTART;
          end
          ST_FAULT: state_q <= ST_FAULT;
          ST_SOFTSTART: begin
            if (charge_level >= target_q) state_q <= ST_ABSORB;
          end
          ST_ABSORB: begin
            // Taper only matters here, never ends charging
            if (cv_seen_q && (abs_tmr_q >= absmax_q || s_taper))
              state_q <= ST_CCCV;
          end
          ST_CCCV: begin
            if (eq_arm_q && s_cv) state_q <= ST_EQUALIZE;
          end
          ST_EQUALIZE: begin
            // Dropping the request pin early abandons equalization
            if (eq_tmr_q >= eqtime_q || !s_eq) state_q <= ST_CCCV;
          end
          default: state_q <= ST_SUSPEND;
        endcase
      end
    end
  end

  // Seconds spent in detection phases
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      sec_cnt_q <= 3'h0;
    end else if (ce) begin
      if (state_q != ST_DETECT && state_q != ST_OPENSHORT) sec_cnt_q <= 3'h0;
      else if (sec_tick && sec_cnt_q + 3'h1 >= (state_q == ST_DETECT ? DET_SECS : OS_SECS))
        sec_cnt_q <= 3'h0;
      else if (sec_tick) sec_cnt_q <= sec_cnt_q + 3'h1;
    end
  end

  // Phase timers, saturating, cleared outside their phase
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      abs_tmr_q <= 16'h0;
      eq_tmr_q  <= 16'h0;
    end else if (ce) begin
      if (state_q != ST_ABSORB) abs_tmr_q <= 16'h0;
      else if (sec_tick && abs_tmr_q != 16'hFFFF) abs_tmr_q <= abs_tmr_q + 16'h1;
      if (state_q != ST_EQUALIZE) eq_tmr_q <= 16'h0;
      else if (sec_tick && eq_tmr_q != 16'hFFFF) eq_tmr_q <= eq_tmr_q + 16'h1;
    end
  end

  // Absorb voltage reached latch and equalize arming
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      cv_seen_q <= 1'b0;
      eq_arm_q  <= 1'b0;
      eq_prev_q <= 1'b0;
    end else if (ce) begin
      eq_prev_q <= s_eq;
      cv_seen_q <= (state_q == ST_ABSORB) && (cv_seen_q || s_cv);
      // Rising edge arms; falling pin or starting equalize disarms
      if (s_eq && !eq_prev_q) eq_arm_q <= 1'b1;
      else if (!s_eq || state_q == ST_EQUALIZE) eq_arm_q <= 1'b0;
    end
  end

  // Low battery hysteresis
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      low_q <= 1'b0;
    end else if (ce) begin
      if (s_lo) low_q <= 1'b1;
      else if (s_hi) low_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Commanded current and voltage
  // ----------------------------------------------------------------
  logic charging;
  assign charging = (state_q == ST_ABSORB) || (state_q == ST_CCCV) ||
                    (state_q == ST_EQUALIZE);

  // Level above target is pulled back to target on the next cycle; limits and CV only step it down
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      charge_level <= 5'h0;
    end else if (ce) begin
      if (!charging && state_q != ST_SOFTSTART) begin
        charge_level <= 5'h0; // minimum for open/short test
      end else if (charge_level > target_q) begin
        charge_level <= target_q;
      end else if (step_tick) begin
        if (charging && regulate && charge_level != 5'h0)
          charge_level <= charge_level - 5'h1;
        else if (!(charging && regulate) && charge_level < target_q)
          charge_level <= charge_level + 5'h1;
      end
    end
  end

  // Voltage code above 2V/cell; adder only in its phase
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      charge_voltage_code <= R_VFLOAT;
    end else if (ce) begin
      case (state_q)
        ST_ABSORB:   charge_voltage_code <= sat_add(vfloat_q, absadd_q);
        ST_EQUALIZE: charge_voltage_code <= sat_add(vfloat_q, eqadd_q);
        default:     charge_voltage_code <= vfloat_q;
      endcase
    end
  end

  // Power stage enables
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      charger_on        <= 1'b0;
      detect_load_on    <= 1'b0;
      peak_current_mode <= 1'b0;
    end else if (ce) begin
      charger_on <= !suspend_req && (charging || state_q == ST_SOFTSTART ||
                    state_q == ST_OPENSHORT);
      detect_load_on <= !suspend_req && state_q == ST_DETECT;
      peak_current_mode <= low_q && charging;
    end
  end

  // ----------------------------------------------------------------
  // Status and detection-fault alert
  // ----------------------------------------------------------------
  always_comb begin
    st_word = 32'h0;
    st_word[int'(state_q)] = 1'b1; // one-hot phase, absorb is bit 5
    st_word[8]  = s_cv && charging;
    st_word[9]  = charging && !regulate && charge_level == target_q;
    st_word[10] = s_icl;
    st_word[11] = s_uvcl;
    st_word[12] = low_q;
    st_word[13] = eq_arm_q;
  end

  // Sticky fault event; a new fault beats a clearing write
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      evt_q <= 1'b0;
      alert <= 1'b0;
    end else if (ce) begin
      if (det_fault) evt_q <= 1'b1;
      else if (wr_acc && address == A_EVENT && byteenable[0] && writedata[0])
        evt_q <= 1'b0;
      alert <= evt_q && ctrl_q[C_IRQ_EN];
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = wait_q;
endmodule : lac_sequencer
`default_nettype wire

// ==== logic/lac_tick.sv ====
// Step and one-second tick generator
`timescale 1ns/1ns
`default_nettype none
module lac_tick #(
  parameter int STEP_N = 50000,
  parameter int SEC_N  = 125000000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Ticks
  output logic      step_tick,
  output logic      sec_tick
);
  logic [31:0] step_cnt_q;
  logic [31:0] sec_cnt_q;

  // Free-running dividers; one-cycle pulses at wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_q <= 32'h0;
      sec_cnt_q  <= 32'h0;
      step_tick  <= 1'b0;
      sec_tick   <= 1'b0;
    end else if (ce) begin
      step_tick <= (step_cnt_q == 32'(STEP_N - 1));
      sec_tick  <= (sec_cnt_q == 32'(SEC_N - 1));
      step_cnt_q <= (step_cnt_q == 32'(STEP_N - 1)) ? 32'h0 : step_cnt_q + 32'h1;
      sec_cnt_q  <= (sec_cnt_q == 32'(SEC_N - 1)) ? 32'h0 : sec_cnt_q + 32'h1;
    end
  end
endmodule : lac_tick
`default_nettype wire

// ==== shared/lac_pkg.sv ====
// Constants shared by the lead-acid charge sequencer
package lac_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 125;
  localparam int STEP_US       = 400;
  localparam int STEP_CYC      = STEP_US * CLK_MHZ;
  localparam int SEC_MS        = 1000;
  localparam int SEC_CYC       = SEC_MS * 1000 * CLK_MHZ;
  localparam logic [2:0] DET_SECS = 3'h3; // 2..3 s with tick phase
  localparam logic [2:0] OS_SECS  = 3'h2; // 2 s exactly, entered on a tick

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] A_CTRL   = 6'h00;
  localparam logic [5:0] A_TARGET = 6'h04;
  localparam logic [5:0] A_VFLOAT = 6'h08;
  localparam logic [5:0] A_ABSADD = 6'h0C;
  localparam logic [5:0] A_EQADD  = 6'h10;
  localparam logic [5:0] A_ABSMAX = 6'h14;
  localparam logic [5:0] A_EQTIME = 6'h18;
  localparam logic [5:0] A_STATUS = 6'h1C;
  localparam logic [5:0] A_EVENT  = 6'h20;

  // Control bit positions
  localparam int C_SUSPEND = 0;
  localparam int C_PROG    = 1;
  localparam int C_IRQ_EN  = 2;

  // Reset values
  localparam logic [2:0]  R_CTRL   = 3'h0;
  localparam logic [4:0]  R_TARGET = 5'h1F;
  localparam logic [5:0]  R_VFLOAT = 6'h15;
  localparam logic [5:0]  R_ABSADD = 6'h15;
  localparam logic [5:0]  R_EQADD  = 6'h2A;
  localparam logic [15:0] R_ABSMAX = 16'h1518;
  localparam logic [15:0] R_EQTIME = 16'h0E10;
  localparam logic [5:0]  V_MAX    = 6'h3F;

  typedef enum logic [2:0] {
    ST_SUSPEND, ST_DETECT, ST_OPENSHORT, ST_FAULT,
    ST_SOFTSTART, ST_ABSORB, ST_CCCV, ST_EQUALIZE
  } lac_state_e;
endpackage : lac_pkg

// ==== sim/lac_batt_model.sv ====
// Behavioural battery and power stage facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module lac_batt_model (
  // Commands from the sequencer
  input  wire logic charger_on,
  // Pack condition set by the bench
  input  wire logic healthy,
  input  wire logic full,
  input  wire logic taper,
  input  wire logic low,
  // Comparator outputs
  output logic      bat_stable,
  output logic      bat_in_range,
  output logic      at_charge_voltage,
  output logic      below_taper,
  output logic      bat_below_2v4,
  output logic      bat_above_2v6
);
  // A sound pack holds under load and after the short charge
  assign bat_stable        = healthy;
  assign bat_in_range      = healthy;
  // Voltage and taper only mean something while current flows
  assign at_charge_voltage = full && charger_on;
  assign below_taper       = taper && charger_on;
  // No hysteresis band: exactly one comparator is set at any time
  assign bat_below_2v4     = low;
  assign bat_above_2v6     = !low;
endmodule : lac_batt_model
`default_nettype wire

// ==== sim/lac_sequencer_monitor.sv ====
// Port-level checker for the lead-acid charge sequencer
`timescale 1ns/1ns
`default_nettype none
module lac_sequencer_monitor import lac_pkg::*; #(
  parameter int STEP_N = 4,
  parameter int SEC_N  = 20
) (
  // Clock, reset, enable
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ce,
  // Register bus
  input wire logic       read,
  input wire logic       write,
  input wire logic       waitrequest,
  // Condition inputs
  input wire logic       vin_near_bat,
  input wire logic       system_fault,
  input wire logic       thermistor_open,
  input wire logic       bat_below_2v4,
  input wire logic       bat_above_2v6,
  // Power stage commands
  input wire logic [4:0] charge_level,
  input wire logic       charger_on,
  input wire logic       detect_load_on,
  input wire logic       peak_current_mode
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  localparam int DMIN = (int'(DET_SECS) - 1) * SEC_N - 1;
  localparam int DMAX = int'(DET_SECS) * SEC_N + 2;
  logic [4:0]  lvl_q;
  logic        chg_q;
  logic [15:0] gap_q;
  logic [15:0] det_q;
  logic        lvl_step;
  // One-LSB move while charging; jumps on suspend are not steps
  assign lvl_step = charger_on && chg_q && (charge_level == lvl_q + 5'h01 || charge_level == lvl_q - 5'h01);
  // Gap since last step and length of the detect load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 5'h00;
      chg_q <= 1'b0;
      gap_q <= 16'hFFFF;
      det_q <= 16'h0000;
    end else begin
      lvl_q <= charge_level;
      chg_q <= charger_on;
      gap_q <= lvl_step ? 16'h0000 : (gap_q == 16'hFFFF ? gap_q : gap_q + 16'h0001);
      det_q <= !detect_load_on ? 16'h0000 : (det_q == 16'hFFFF ? det_q : det_q + 16'h0001);
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_ans;
    !waitrequest ##1 waitrequest;
  endsequence
  a_bus_one_wait: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle after request");
  a_level_step: assert property (charger_on && chg_q && charge_level != lvl_q |-> lvl_step)
    else $error("charge level moved by more than one");
  a_step_spacing: assert property (lvl_step |-> gap_q >= STEP_N - 1)
    else $error("charge level steps too close");
  a_suspend_stops: assert property ((system_fault || vin_near_bat)[*3] |-> ##[0:5] !charger_on)
    else $error("charger still on under suspend condition");
  a_detect_min: assert property ($fell(detect_load_on) && !system_fault && !vin_near_bat && !thermistor_open
    |-> det_q >= DMIN)
    else $error("detect load ended early");
  a_detect_max: assert property (det_q <= DMAX)
    else $error("detect load held too long");
  a_peak_enter: assert property ((bat_below_2v4 && charger_on)[*4] |-> ##[0:3] peak_current_mode)
    else $error("peak mode missing on low battery");
  a_peak_leave: assert property ((bat_above_2v6 && !bat_below_2v4)[*4] |-> ##[0:3] !peak_current_mode)
    else $error("peak mode kept above upper threshold");
endmodule : lac_sequencer_monitor

bind lac_sequencer lac_sequencer_monitor #(.STEP_N(STEP_N), .SEC_N(SEC_N)) u_mon (
  .clk(clk), .rst_n(rst_n), .ce(ce), .read(read), .write(write), .waitrequest(waitrequest),
  .vin_near_bat(vin_near_bat), .system_fault(system_fault), .thermistor_open(thermistor_open),
  .bat_below_2v4(bat_below_2v4), .bat_above_2v6(bat_above_2v6), .charge_level(charge_level),
  .charger_on(charger_on), .detect_load_on(detect_load_on), .peak_current_mode(peak_current_mode)
);
`default_nettype wire

// ==== sim/lac_sequencer_tb.sv ====
// Self-checking bench for the lead-acid charge sequencer
`timescale 1ns/1ns
`default_nettype none
module lac_sequencer_tb import lac_pkg::*;;
  localparam int SN = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        vin_near_bat = 1'b0;
  logic        system_fault = 1'b1;
  logic        thermistor_open = 1'b0;
  logic [1:0]  lim = 2'h0;
  logic        eq_pin = 1'b0;
  logic        ce = 1'b1;
  logic        healthy = 1'b0;
  logic        full = 1'b0;
  logic        taper = 1'b0;
  logic        low = 1'b0;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic [4:0]  charge_level;
  logic [5:0]  charge_voltage_code;
  logic        waitrequest, charger_on, detect_load_on, peak_current_mode, alert;
  logic        stable, in_range, at_cv, b_taper, b24, b26;
  int          errors = 0;
  int          n_checks = 0;
  logic [5:0]  ra [8] = '{A_CTRL, A_TARGET, A_VFLOAT, A_ABSADD, A_EQADD, A_ABSMAX, A_EQTIME, 6'h24};
  logic [31:0] rv [8] = '{32'(R_CTRL), 32'(R_TARGET), 32'(R_VFLOAT), 32'(R_ABSADD), 32'(R_EQADD),
                          32'(R_ABSMAX), 32'(R_EQTIME), 32'h0};
  logic [31:0] wv [6] = '{32'h5, 32'h30, 32'h15, 32'h5, 32'h2, 32'h2};

  always #4 clk = ~clk;

  lac_sequencer #(.STEP_N(4), .SEC_N(SN)) dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .address(address), .read(read), .write(write),
    .byteenable(4'hF), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .vin_near_bat(vin_near_bat), .system_fault(system_fault), .bat_stable(stable), .bat_in_range(in_range),
    .thermistor_open(thermistor_open), .bat_below_2v4(b24), .bat_above_2v6(b26), .at_charge_voltage(at_cv),
    .input_current_limiting(lim[0]), .undervoltage_limiting(lim[1]), .below_taper(b_taper),
    .equalize_request_pin(eq_pin), .charge_level(charge_level), .charge_voltage_code(charge_voltage_code),
    .charger_on(charger_on), .detect_load_on(detect_load_on), .peak_current_mode(peak_current_mode),
    .alert(alert));

  lac_batt_model u_batt (
    .charger_on(charger_on), .healthy(healthy), .full(full), .taper(taper), .low(low),
    .bat_stable(stable), .bat_in_range(in_range), .at_charge_voltage(at_cv), .below_taper(b_taper),
    .bat_below_2v4(b24), .bat_above_2v6(b26));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 64) chk("bus answer", 32'h0, 32'h1);
  endtask : bus

  // Poll status until a phase bit shows, bounded
  task automatic wait_phase(input int b, input int tries);
    int k;
    k = 0;
    do begin
      bus(1'b0, A_STATUS, 32'h0);
      k++;
    end while (rd[b] !== 1'b1 && k < tries);
    chk("phase bit", 32'h1, {31'h0, rd[b]});
  endtask : wait_phase

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk("reset value", rv[i], rd);
    end
    bus(1'b0, A_STATUS, 32'h0);
    chk("suspended", 32'h01, {24'h0, rd[7:0]});
    bus(1'b1, A_TARGET, 32'h5);
    bus(1'b0, A_TARGET, 32'h0);
    chk("locked target", 32'(R_TARGET), rd);
    bus(1'b1, A_CTRL, 32'h6);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, ra[i + 1], wv[i]);
      bus(1'b0, ra[i + 1], 32'h0);
      chk("setting", wv[i], rd);
    end
    // Failing pack: detect, open/short, fault, alert
    system_fault <= 1'b0;
    wait_phase(1, 40);
    chk("detect load", 32'h1, {31'h0, detect_load_on});
    wait_phase(2, 60);
    chk("min level", 32'h0, {27'h0, charge_level});
    wait_phase(3, 60);
    bus(1'b0, A_EVENT, 32'h0);
    chk("fault event", 32'h1, {31'h0, rd[0]});
    chk("alert on", 32'h1, {31'h0, alert});
    bus(1'b1, A_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    chk("alert masked", 32'h0, {31'h0, alert});
    // Open thermistor during detect
    healthy <= 1'b1;
    thermistor_open <= 1'b1;
    bus(1'b1, A_CTRL, 32'h3);
    bus(1'b1, A_CTRL, 32'h2);
    wait_phase(3, 40);
    thermistor_open <= 1'b0;
    bus(1'b1, A_CTRL, 32'h3);
    bus(1'b1, A_CTRL, 32'h2);
    // Good pack: soft-start into absorb with clamped target
    wait_phase(4, 60);
    wait_phase(5, 20);
    chk("ramp end", 32'h5, {27'h0, charge_level});
    chk("absorb code", 32'h3F, {26'h0, charge_voltage_code});
    low <= 1'b1;
    repeat (8) @(posedge clk);
    chk("peak mode", 32'h1, {31'h0, peak_current_mode});
    low <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      lim <= 2'(1 << i);
      repeat (24) @(posedge clk);
      bus(1'b0, A_STATUS, 32'h0);
      chk("limit flag", 32'h1, {31'h0, rd[10 + i]});
      chk("level cut", 32'h1, {31'h0, charge_level < 5'h05});
      lim <= 2'h0;
      repeat (40) @(posedge clk);
      chk("level back", 32'h5, {27'h0, charge_level});
    end
    // Enable low freezes the level even under a limit
    ce <= 1'b0;
    lim <= 2'h1;
    repeat (24) @(posedge clk);
    chk("frozen level", 32'h5, {27'h0, charge_level});
    ce <= 1'b1;
    lim <= 2'h0;
    // Taper and timer alone never end absorb
    taper <= 1'b1;
    repeat (5 * SN) @(posedge clk);
    bus(1'b0, A_STATUS, 32'h0);
    chk("still absorb", 32'h1, {31'h0, rd[5]});
    full <= 1'b1;
    wait_phase(6, 30);
    chk("cv flag", 32'h1, {31'h0, rd[8]});
    chk("float code", 32'h30, {26'h0, charge_voltage_code});
    // Equalize once per pin edge
    eq_pin <= 1'b1;
    wait_phase(7, 30);
    chk("eq code", 32'h35, {26'h0, charge_voltage_code});
    wait_phase(6, 40);
    repeat (3 * SN) @(posedge clk);
    bus(1'b0, A_STATUS, 32'h0);
    chk("no re-arm", 32'h1, {31'h0, rd[6]});
    eq_pin <= 1'b0;
    // Input collapse suspends
    vin_near_bat <= 1'b1;
    wait_phase(0, 10);
    chk("charger off", 32'h0, {31'h0, charger_on});
    close_out();
  end
endmodule : lac_sequencer_tb
`default_nettype wire
